// ==== hw/rch_core.sv ====
/*
  Command handshake engine, register slave and status indicators of an
  RFID read/write head channel.
  Assumes a synchronous reader back end that pulses rf_done_in once per
  started command, and status inputs synchronous to clk_in.
*/
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`include "rch_map.svh"

module rch_core #(
  parameter int TIMEOUT_CYC = `RCH_TIMEOUT_MS * `RCH_CLK_KHZ,
  parameter int BLINK_HALF_CYC = `RCH_BLINK_HALF_MS * `RCH_CLK_KHZ
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Reader back end
  output logic rf_start_out,
  output logic [15:0] rf_cmd_out,
  output logic rf_on_out,
  input wire logic rf_done_in,
  input wire logic rf_err_in,
  input wire logic [15:0] rf_len_in,
  input wire logic tag_present_in,
  input wire logic air_xfer_in,
  // Indicator status sources
  input wire logic [1:0] supply_state_in,
  input wire logic [2:0] bus_state_in,
  input wire logic link_up_in,
  input wire logic link_100_in,
  input wire logic link_act_in,
  // Indicator lamps
  output logic [1:0] supply_indicator_out,
  output logic [1:0] rf_field_indicator_out,
  output logic [1:0] tag_indicator_out,
  output logic [1:0] bus_indicator_out,
  output logic [1:0] link_indicator_out
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter checks and helpers

  if (TIMEOUT_CYC < 1 || BLINK_HALF_CYC < 1) begin : g_chk
    $error("rch_core: counts must be at least one cycle");
  end

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] sel);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus and engine state

  rch_pkg::rch_state_t state, next_state;
  rch_pkg::rch_mode_t mode, next_mode;
  logic [15:0] cmd, next_cmd;
  logic fast, next_fast;
  logic [7:0] loop_cnt, next_loop_cnt;
  logic [7:0] frag_req, next_frag_req;
  logic [15:0] resp, next_resp;
  logic [7:0] loop_echo, next_loop_echo;
  logic [7:0] frag, next_frag;
  logic [15:0] remain, next_remain;
  logic [15:0] ifsz, next_ifsz;
  logic [7:0] results, next_results;
  logic err, next_err;
  logic tmo, next_tmo;
  logic [31:0] tmo_cnt, next_tmo_cnt;
  logic start, next_start;
  logic rf_on, next_rf_on;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic wr;
  logic [31:0] wword;

  // Write takes effect at the edge where ack is sampled
  assign wr = wb_cyc_in && wb_stb_in && wb_we_in && ack;

  // Next values of bus slave and command engine
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_cmd = cmd;
    next_fast = fast;
    next_loop_cnt = loop_cnt;
    next_frag_req = frag_req;
    next_resp = resp;
    next_loop_echo = loop_echo;
    next_frag = frag;
    next_remain = remain;
    next_ifsz = ifsz;
    next_results = results;
    next_err = err;
    next_tmo = tmo;
    next_tmo_cnt = tmo_cnt;
    next_start = 1'b0;
    wword = 32'h0000_0000;
    // Single-wait-state answer, dropped the cycle after
    next_ack = wb_cyc_in && wb_stb_in && !ack;
    next_rdat = rdat;
    if (wb_cyc_in && wb_stb_in && !ack && !wb_we_in) begin
      case (wb_adr_in)
        `RCH_ADR_CMD: next_rdat = {15'h0000, fast, cmd};
        `RCH_ADR_LOOP: next_rdat = {16'h0000, frag_req, loop_cnt};
        `RCH_ADR_MODE: next_rdat = {30'h0000_0000, mode};
        `RCH_ADR_RESP: next_rdat = {frag, loop_echo, resp};
        `RCH_ADR_STAT: next_rdat = {16'h0000, results, 5'h00, tmo, err,
            (state != rch_pkg::RCH_IDLE)};
        `RCH_ADR_IFSZ: next_rdat = {16'h0000, ifsz};
        default: next_rdat = 32'h0000_0000;
      endcase
    end
    // Timeout on any running command
    if (state != rch_pkg::RCH_IDLE) begin
      next_tmo_cnt = tmo_cnt + 32'h0000_0001;
      if (tmo_cnt >= TIMEOUT_CYC - 1) begin
        next_state = rch_pkg::RCH_IDLE;
        next_tmo = 1'b1;
      end
    end
    // Reader completion
    case (state)
      rch_pkg::RCH_WAIT_TAG: begin
        if (tag_present_in && next_state != rch_pkg::RCH_IDLE) begin
          next_state = rch_pkg::RCH_EXEC;
          next_start = 1'b1;
        end
      end
      rch_pkg::RCH_EXEC: begin
        if (rf_done_in) begin
          next_tmo_cnt = 32'h0000_0000;
          if (rf_err_in) begin
            next_err = 1'b1;
          end else begin
            next_resp = cmd;
            next_loop_echo = loop_cnt;
            if (rf_len_in > ifsz) begin
              next_frag = 8'h01;
              next_remain = rf_len_in - ifsz;
            end else begin
              next_frag = 8'h00;
              next_remain = 16'h0000;
            end
            // Results counted in the interface only
            next_results = results + 8'h01;
          end
          case (mode)
            rch_pkg::RCH_CONTINUOUS: begin
              next_start = 1'b1;
            end
            rch_pkg::RCH_PRESENCE: next_state = rch_pkg::RCH_WAIT_TAG;
            default: next_state = rch_pkg::RCH_IDLE;
          endcase
        end
      end
      default: ;
    endcase
    // Register writes
    if (wr) begin
      case (wb_adr_in)
        `RCH_ADR_CMD: begin
          wword = merge({15'h0000, fast, cmd}, wb_dat_in, wb_sel_in);
          next_cmd = wword[15:0];
          next_fast = wword[`RCH_CMD_FAST_BIT];
          next_resp = 16'h0000;
          next_frag = 8'h00;
          next_remain = 16'h0000;
          next_tmo_cnt = 32'h0000_0000;
          next_start = 1'b0;
          if (wword[15:0] == `RCH_CMD_TERM) begin
            next_state = rch_pkg::RCH_IDLE;
          end else if (mode == rch_pkg::RCH_PRESENCE) begin
            next_state = rch_pkg::RCH_WAIT_TAG;
          end else begin
            next_state = rch_pkg::RCH_EXEC;
            next_start = 1'b1;
          end
        end
        `RCH_ADR_LOOP: begin
          wword = merge({16'h0000, frag_req, loop_cnt}, wb_dat_in,
              wb_sel_in);
          next_loop_cnt = wword[7:0];
          next_frag_req = wword[15:8];
          // Repeat only fast commands on a loop step of one
          if (fast && state == rch_pkg::RCH_IDLE && loop_cnt != 8'h00
              && wword[7:0] == loop_cnt + 8'h01) begin
            next_state = rch_pkg::RCH_EXEC;
            next_start = 1'b1;
            next_tmo_cnt = 32'h0000_0000;
          end
          // Next fragment on a changed fragment request
          if (remain != 16'h0000 && wword[15:8] != frag_req) begin
            if (remain > ifsz) begin
              next_frag = frag + 8'h01;
              next_remain = remain - ifsz;
            end else begin
              next_frag = 8'h00;
              next_remain = 16'h0000;
            end
          end
        end
        `RCH_ADR_MODE: begin
          wword = merge({30'h0000_0000, mode}, wb_dat_in, wb_sel_in);
          next_mode = rch_pkg::rch_mode_t'(wword[1:0]);
        end
        `RCH_ADR_STAT: begin
          // Write one to clear; a same-cycle event still sets err or tmo, but a same-cycle success is not added to results
          if (wb_sel_in[0] && wb_dat_in[`RCH_STAT_ERR_BIT]) begin
            next_err = rf_done_in && rf_err_in
                && state == rch_pkg::RCH_EXEC;
          end
          if (wb_sel_in[0] && wb_dat_in[`RCH_STAT_TMO_BIT]) begin
            next_tmo = state != rch_pkg::RCH_IDLE
                && tmo_cnt >= TIMEOUT_CYC - 1;
          end
          if (wb_sel_in[1] && wb_dat_in[15:8] != 8'h00) begin
            next_results = 8'h00;
          end
        end
        `RCH_ADR_IFSZ: begin
          wword = merge({16'h0000, ifsz}, wb_dat_in, wb_sel_in);
          next_ifsz = wword[15:0];
        end
        default: ;
      endcase
    end
    next_rf_on = next_state == rch_pkg::RCH_EXEC;
  end

  // Register bus and engine state
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= rch_pkg::RCH_IDLE;
      mode <= rch_pkg::RCH_SINGLE;
      cmd <= 16'h0000;
      fast <= 1'b0;
      loop_cnt <= 8'h00;
      frag_req <= 8'h00;
      resp <= 16'h0000;
      loop_echo <= 8'h00;
      frag <= 8'h00;
      remain <= 16'h0000;
      ifsz <= `RCH_IFSZ_RST;
      results <= 8'h00;
      err <= 1'b0;
      tmo <= 1'b0;
      tmo_cnt <= 32'h0000_0000;
      start <= 1'b0;
      rf_on <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      state <= next_state;
      mode <= next_mode;
      cmd <= next_cmd;
      fast <= next_fast;
      loop_cnt <= next_loop_cnt;
      frag_req <= next_frag_req;
      resp <= next_resp;
      loop_echo <= next_loop_echo;
      frag <= next_frag;
      remain <= next_remain;
      ifsz <= next_ifsz;
      results <= next_results;
      err <= next_err;
      tmo <= next_tmo;
      tmo_cnt <= next_tmo_cnt;
      start <= next_start;
      rf_on <= next_rf_on;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  assign wb_ack_out = ack;
  assign wb_dat_out = rdat;
  assign rf_start_out = start;
  assign rf_cmd_out = cmd;
  assign rf_on_out = rf_on;

  ////////////////////////////////////////////////////////////////////////
  // Indicator lamps

  logic [31:0] blink_cnt, next_blink_cnt;
  logic phase, next_phase;
  rch_pkg::rch_led_t led_sup, next_led_sup;
  rch_pkg::rch_led_t led_rf, next_led_rf;
  rch_pkg::rch_led_t led_tag, next_led_tag;
  rch_pkg::rch_led_t led_bus, next_led_bus;
  rch_pkg::rch_led_t led_lnk, next_led_lnk;

  // Shared timebase and lamp colours
  always_comb begin
    next_blink_cnt = blink_cnt + 32'h0000_0001;
    next_phase = phase;
    if (blink_cnt >= BLINK_HALF_CYC - 1) begin
      next_blink_cnt = 32'h0000_0000;
      next_phase = !phase;
    end
    next_led_sup = rch_pkg::rch_led_t'(supply_state_in);
    next_led_rf = rf_on ? rch_pkg::RCH_GREEN : rch_pkg::RCH_OFF;
    next_led_tag = (tag_present_in && air_xfer_in && phase)
        ? rch_pkg::RCH_YELLOW : rch_pkg::RCH_OFF;
    case (bus_state_in)
      rch_pkg::RCH_BUS_MASTER: next_led_bus = rch_pkg::RCH_GREEN;
      rch_pkg::RCH_BUS_OPER:
        next_led_bus = phase ? rch_pkg::RCH_GREEN : rch_pkg::RCH_OFF;
      rch_pkg::RCH_BUS_CONFLICT: next_led_bus = rch_pkg::RCH_RED;
      rch_pkg::RCH_BUS_WINK:
        next_led_bus = phase ? rch_pkg::RCH_RED : rch_pkg::RCH_OFF;
      rch_pkg::RCH_BUS_NEGOT:
        next_led_bus = phase ? rch_pkg::RCH_RED : rch_pkg::RCH_GREEN;
      default: next_led_bus = rch_pkg::RCH_OFF;
    endcase
    if (!link_up_in) begin
      next_led_lnk = rch_pkg::RCH_OFF;
    end else if (link_act_in && !phase) begin
      next_led_lnk = rch_pkg::RCH_OFF;
    end else begin
      next_led_lnk = link_100_in ? rch_pkg::RCH_GREEN : rch_pkg::RCH_YELLOW;
    end
  end

  // Register timebase and lamps
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      blink_cnt <= 32'h0000_0000;
      phase <= 1'b0;
      led_sup <= rch_pkg::RCH_OFF;
      led_rf <= rch_pkg::RCH_OFF;
      led_tag <= rch_pkg::RCH_OFF;
      led_bus <= rch_pkg::RCH_OFF;
      led_lnk <= rch_pkg::RCH_OFF;
    end else begin
      blink_cnt <= next_blink_cnt;
      phase <= next_phase;
      led_sup <= next_led_sup;
      led_rf <= next_led_rf;
      led_tag <= next_led_tag;
      led_bus <= next_led_bus;
      led_lnk <= next_led_lnk;
    end
  end

  assign supply_indicator_out = led_sup;
  assign rf_field_indicator_out = led_rf;
  assign tag_indicator_out = led_tag;
  assign bus_indicator_out = led_bus;
  assign link_indicator_out = led_lnk;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  logic exec_done_ok;
  assign exec_done_ok = state == rch_pkg::RCH_EXEC && rf_done_in
      && !rf_err_in && !wr;

  a_resp_echo: assert property (exec_done_ok |=> resp == $past(cmd))
    else $error("response code differs from command code");
  a_loop_echo: assert property (
    exec_done_ok |=> loop_echo == $past(loop_cnt))
    else $error("loop counter not echoed");
  a_frag_big: assert property (
    exec_done_ok && rf_len_in > ifsz |=> frag == 8'h01)
    else $error("fragment counter not raised");
  a_frag_fits: assert property (
    exec_done_ok && rf_len_in <= ifsz |=> frag == 8'h00)
    else $error("fragment counter not zero");
  a_loop_slow: assert property (
    wr && wb_adr_in == `RCH_ADR_LOOP && !fast && state == rch_pkg::RCH_IDLE
    |=> state == rch_pkg::RCH_IDLE && !rf_start_out)
    else $error("slow command repeated by loop counter");
  a_cont_repeat: assert property (
    exec_done_ok && mode == rch_pkg::RCH_CONTINUOUS |=> rf_start_out)
    else $error("continuous mode did not repeat");
  a_inv_single: assert property (
    exec_done_ok && mode == rch_pkg::RCH_INVENTORY
    |=> state == rch_pkg::RCH_IDLE ##1 !rf_on_out)
    else $error("inventory did not end");
  a_presence_go: assert property (
    state == rch_pkg::RCH_WAIT_TAG && tag_present_in && !wr
    && tmo_cnt < TIMEOUT_CYC - 1 |=> rf_start_out && rf_on_out)
    else $error("reader not started on tag");
  a_field_lamp: assert property (
    rf_on_out |=> rf_field_indicator_out == rch_pkg::RCH_GREEN)
    else $error("field lamp not green");
  a_phase_half: assert property (
    $changed(phase) |=> $stable(phase))
    else $error("timebase phase too short");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");

  c_success: cover property (exec_done_ok ##1 resp != 16'h0000);
  c_fragment: cover property (exec_done_ok && rf_len_in > ifsz);
  c_loop: cover property (wr && wb_adr_in == `RCH_ADR_LOOP && fast);
  c_presence: cover property (state == rch_pkg::RCH_WAIT_TAG
      && tag_present_in);

endmodule

// ==== inc/rch_map.svh ====
/*
  Register offsets, field positions, reset values and timing figures
  of the RFID command handshake block.
  Assumes a 10 MHz clock and a 32-bit classic Wishbone register bus.
*/
`ifndef RCH_MAP_SVH
`define RCH_MAP_SVH

// Byte addresses of the register words
`define RCH_ADR_CMD 8'h00
`define RCH_ADR_LOOP 8'h04
`define RCH_ADR_MODE 8'h08
`define RCH_ADR_RESP 8'h0C
`define RCH_ADR_STAT 8'h10
`define RCH_ADR_IFSZ 8'h14

// Field positions
`define RCH_CMD_FAST_BIT 16
`define RCH_STAT_BUSY_BIT 0
`define RCH_STAT_ERR_BIT 1
`define RCH_STAT_TMO_BIT 2

// Reset values and special codes
`define RCH_IFSZ_RST 16'h0080
`define RCH_CMD_TERM 16'h0000

// Timing figures in their own units
`define RCH_CLK_KHZ 10000
`define RCH_TIMEOUT_MS 100
`define RCH_BLINK_HALF_MS 500

`endif

// ==== inc/rch_pkg.sv ====
/*
  Types of the RFID command handshake block.
  Assumes rch_map.svh for all numeric constants.
*/
package rch_pkg;
  // Engine states
  typedef enum {RCH_IDLE, RCH_WAIT_TAG, RCH_EXEC} rch_state_t;
  // Command modes held in the mode register
  typedef enum logic [1:0] {
    RCH_SINGLE, RCH_INVENTORY, RCH_CONTINUOUS, RCH_PRESENCE
  } rch_mode_t;
  // Indicator colour on a two-bit lamp port
  typedef enum logic [1:0] {
    RCH_OFF, RCH_GREEN, RCH_YELLOW, RCH_RED
  } rch_led_t;
  // Network bus status reported by the network stack
  typedef enum logic [2:0] {
    RCH_BUS_NONE, RCH_BUS_MASTER, RCH_BUS_OPER, RCH_BUS_CONFLICT,
    RCH_BUS_WINK, RCH_BUS_NEGOT
  } rch_bus_t;
endpackage

// ==== tb/rch_rdr_model.sv ====
/*
  Behavioural reader back end facing the command handshake block.
  Assumes one rf_start pulse per command; the bench sets delay, error
  and length of the answer, delay 8'hFF meaning no answer at all.
*/
`timescale 1ns/10ps

module rch_rdr_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Start from the block
  input wire logic rf_start_in,
  // Answer shape from the bench
  input wire logic [7:0] delay_in,
  input wire logic err_in,
  input wire logic [15:0] len_in,
  // Answer to the block
  output logic rf_done_out,
  output logic rf_err_out,
  output logic [15:0] rf_len_out
);
  logic busy, next_busy, next_done, next_err;
  logic [7:0] cnt, next_cnt;
  logic [15:0] next_len;

  ////////////////////////////////////////////////////////////////////////
  // One answer per start; released lines toggle every cycle
  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_done = 1'b0;
    next_err = ~rf_err_out;
    next_len = ~rf_len_out;
    if (rf_start_in && delay_in != 8'hFF) begin
      next_busy = 1'b1;
      next_cnt = delay_in;
    end else if (busy && cnt == 8'h00) begin
      next_busy = 1'b0;
      next_done = 1'b1;
      next_err = err_in;
      next_len = len_in;
    end else if (busy) begin
      next_cnt = cnt - 8'h01;
    end
  end

  // State registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      rf_done_out <= 1'b0;
      rf_err_out <= 1'b0;
      rf_len_out <= 16'h0000;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      rf_done_out <= next_done;
      rf_err_out <= next_err;
      rf_len_out <= next_len;
    end
  end
endmodule

// ==== tb/tb.sv ====
/*
  Self-checking bench of the RFID command handshake block.
  Assumes rch_core, the reader model and rch_map.svh on the include path.
*/
`timescale 1ns/10ps
`include "rch_map.svh"

module tb;
  logic clk_in, srst_in, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr, m_delay;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic rf_start, rf_on, rf_done, rf_err, tag_present, air_xfer, m_err;
  logic [15:0] rf_cmd, rf_len, m_len, code;
  logic [1:0] supply_state, supply_led, field_led, tag_led, bus_led, link_led;
  logic [2:0] bus_state;
  logic link_up, link_100, link_act;
  int n_mismatch, checks, n_start, n_done, seed, base, base_d;

  rch_core #(.TIMEOUT_CYC(50), .BLINK_HALF_CYC(4)) dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack), .rf_start_out(rf_start), .rf_cmd_out(rf_cmd),
    .rf_on_out(rf_on), .rf_done_in(rf_done), .rf_err_in(rf_err),
    .rf_len_in(rf_len), .tag_present_in(tag_present),
    .air_xfer_in(air_xfer), .supply_state_in(supply_state),
    .bus_state_in(bus_state), .link_up_in(link_up),
    .link_100_in(link_100), .link_act_in(link_act),
    .supply_indicator_out(supply_led), .rf_field_indicator_out(field_led),
    .tag_indicator_out(tag_led), .bus_indicator_out(bus_led),
    .link_indicator_out(link_led));

  rch_rdr_model model_u (
    .clk_in(clk_in), .srst_in(srst_in), .rf_start_in(rf_start),
    .delay_in(m_delay), .err_in(m_err), .len_in(m_len),
    .rf_done_out(rf_done), .rf_err_out(rf_err), .rf_len_out(rf_len));

  ////////////////////////////////////////////////////////////////////////
  // Clock and event counters
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (rf_start === 1'b1) n_start++;
    // Completions that arrive after a terminate are ignored by the block
    if (rf_done === 1'b1 && rf_on === 1'b1) n_done++;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Classic single Wishbone cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 50) chk({31'h0, wb_ack}, 32'h1);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // Poll busy until clear
  task wait_idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, `RCH_ADR_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    chk({31'h0, rd[0]}, 32'h0);
  endtask

  // Mode and loop first, command code last
  task run(input logic [31:0] md, input logic [31:0] c, input logic [31:0] l);
    wb(1'b1, `RCH_ADR_MODE, md);
    wb(1'b1, `RCH_ADR_LOOP, l);
    wb(1'b1, `RCH_ADR_CMD, c);
  endtask

  // Terminate just after a start so no completion collides
  task stop_cmd;
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rf_start !== 1'b1 && n < 100);
    wb(1'b1, `RCH_ADR_CMD, {16'h0, `RCH_CMD_TERM});
    wait_idle;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Expectations
  function logic [7:0] exp_frag(input int len, input int sz, input int k);
    return (len > sz && k + 1 < (len + sz - 1) / sz) ? 8'(k + 1) : 8'h00;
  endfunction

  // Lamp pattern: colour A, other colour, cycles of A in eight
  function logic [7:0] bus_exp(input logic [2:0] s);
    case (s)
      3'h1: return 8'h48;
      3'h2: return 8'h44;
      3'h3: return 8'hC8;
      3'h4: return 8'hC4;
      3'h5: return 8'hD4;
      default: return 8'h08;
    endcase
  endfunction

  function logic [7:0] link_exp(input logic [2:0] i);
    if (!i[2]) return 8'h08;
    return {i[1] ? 2'h1 : 2'h2, 2'h0, i[0] ? 4'h4 : 4'h8};
  endfunction

  function logic [1:0] lampv(input int i);
    case (i)
      0: return supply_led;
      2: return tag_led;
      3: return bus_led;
      default: return link_led;
    endcase
  endfunction

  // Eight cycles span one full flash period
  task lamp(input int i, input logic [7:0] e);
    int n;
    n = 0;
    repeat (2) @(posedge clk_in);
    repeat (8) begin
      @(posedge clk_in);
      if (lampv(i) === e[7:6]) n++;
      else chk({30'h0, lampv(i)}, {30'h0, e[5:4]});
    end
    chk(32'(n), {28'h0, e[3:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    wrap_up;
  end

  // Main sequence
  initial begin
    seed = 47516;
    {wb_cyc, wb_stb, wb_we, m_err, tag_present, air_xfer} = 6'h00;
    {wb_adr, wb_wdat, wb_sel} = {8'h00, 32'h0, 4'hF};
    {supply_state, bus_state, link_up, link_100, link_act} = 8'h00;
    m_delay = 8'h14;
    m_len = 16'h0010;
    srst_in = 1'b1;
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    rdchk(`RCH_ADR_IFSZ, {16'h0, `RCH_IFSZ_RST}, 32'h0000FFFF);
    rdchk(`RCH_ADR_STAT, 32'h0, 32'h0000FF07);
    wb(1'b1, `RCH_ADR_RESP, 32'hFFFFFFFF);
    rdchk(`RCH_ADR_RESP, 32'h0, 32'hFFFFFFFF);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    rdchk(8'h20, 32'h0, 32'hFFFFFFFF);
    $display("test reset finished");
    for (int m = 0; m < 2; m++) begin
      code = 16'($random(seed)) | 16'h0001;
      m_len <= 16'($random(seed) & 32'h7F);
      base = n_start;
      run(32'(m), {16'h0, code}, 32'h0);
      // Field on at the write edge, lamp one edge later
      repeat (2) @(posedge clk_in);
      chk({30'h0, field_led}, 32'h1);
      wait_idle;
      chk({30'h0, field_led}, 32'h0);
      rdchk(`RCH_ADR_RESP, {16'h0, code}, 32'hFFFFFFFF);
      repeat (10) @(posedge clk_in);
      chk(32'(n_start - base), 32'h1);
    end
    $display("test single finished");
    m_delay <= 8'h02;
    m_len <= 16'h0180;
    run(32'h0, {16'h0, code}, 32'h0);
    wait_idle;
    for (int k = 0; k < 3; k++) begin
      if (k > 0) wb(1'b1, `RCH_ADR_LOOP, {16'h0, 8'(k), 8'h00});
      repeat (3) @(posedge clk_in);
      wb(1'b0, `RCH_ADR_RESP, 32'h0);
      chk({24'h0, rd[31:24]}, {24'h0, exp_frag(384, 128, k)});
    end
    $display("test fragment finished");
    m_len <= 16'h0010;
    base = n_start;
    run(32'h0, {15'h0, 1'b1, code}, 32'h1);
    wait_idle;
    rdchk(`RCH_ADR_RESP, {16'h0001, code}, 32'hFFFFFFFF);
    wb(1'b1, `RCH_ADR_LOOP, 32'h2);
    wait_idle;
    rdchk(`RCH_ADR_RESP, {16'h0002, code}, 32'hFFFFFFFF);
    chk(32'(n_start - base), 32'h2);
    base = n_start;
    run(32'h0, {16'h0, code}, 32'h0);
    wait_idle;
    wb(1'b1, `RCH_ADR_LOOP, 32'h1);
    wb(1'b1, `RCH_ADR_LOOP, 32'h2);
    repeat (5) @(posedge clk_in);
    chk(32'(n_start - base), 32'h1);
    $display("test loop finished");
    m_err <= 1'b1;
    run(32'h0, {16'h0, code}, 32'h0);
    wait_idle;
    rdchk(`RCH_ADR_STAT, 32'h2, 32'h7);
    m_err <= 1'b0;
    m_delay <= 8'hFF;
    wb(1'b1, `RCH_ADR_CMD, {16'h0, code});
    repeat (60) @(posedge clk_in);
    rdchk(`RCH_ADR_STAT, 32'h6, 32'h7);
    wb(1'b1, `RCH_ADR_STAT, 32'h0000FF06);
    rdchk(`RCH_ADR_STAT, 32'h0, 32'h0000FF07);
    $display("test fault finished");
    m_delay <= 8'h05;
    base_d = n_done;
    run(32'h2, {16'h0, code}, 32'h0);
    repeat (40) @(posedge clk_in);
    stop_cmd;
    wb(1'b0, `RCH_ADR_STAT, 32'h0);
    chk({24'h0, rd[15:8]}, 32'(n_done - base_d));
    chk(32'(n_done - base_d > 2), 32'h1);
    base = n_start;
    run(32'h3, {16'h0, code}, 32'h0);
    repeat (10) @(posedge clk_in);
    chk(32'(n_start - base), 32'h0);
    tag_present <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(32'(n_start - base), 32'h1);
    stop_cmd;
    tag_present <= 1'b0;
    $display("test modes finished");
    for (int s = 0; s < 4; s++) begin
      supply_state <= 2'(s);
      lamp(0, {2'(s), 2'h0, 4'h8});
    end
    for (int x = 0; x < 2; x++) begin
      {tag_present, air_xfer} <= {2{x[0]}};
      lamp(2, x[0] ? 8'h84 : 8'h08);
    end
    for (int s = 0; s < 7; s++) begin
      bus_state <= 3'(s);
      lamp(3, bus_exp(3'(s)));
    end
    for (int i = 0; i < 8; i++) begin
      {link_up, link_100, link_act} <= 3'(i);
      lamp(4, link_exp(3'(i)));
    end
    $display("test lamps finished");
    wrap_up;
  end
endmodule
